/* File: bcsr_defines.vh */
// constants for the buck channel status register block
`ifndef BCSR_DEFINES_VH
`define BCSR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BCSR_BUCK_TWO_STATUS_OFS 8'h06
`define BCSR_BUCK_THREE_STATUS_OFS 8'h07
`define BCSR_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define BCSR_FAULT_BIT 7
`define BCSR_RETRY_BIT 6
`define BCSR_REVERSE_BIT 5
`define BCSR_ZERO_CROSS_BIT 4
`define BCSR_RESERVED_BIT 3
`define BCSR_RAMP_BIT 2
`define BCSR_REGULATION_BIT 1
`define BCSR_ON_BIT 0
`define BCSR_STATUS_RESET 8'h00

// ----------------------------------------------------------------
// overcurrent event counter and serial port defaults
// ----------------------------------------------------------------
`define BCSR_OC_END_COUNT 8
`define BCSR_OC_COUNT_WIDTH 4
// arbitrary device address value
`define BCSR_DEVICE_ADDRESS 7'h5B
`define BCSR_BYTE_LAST_BIT 3'h7
`define BCSR_BIT_COUNT_ZERO 3'h0

`endif

/* File: bcsr_channel.v */
// one buck channel status register with latched and live bits
`timescale 1ns/100ps
`include "bcsr_defines.vh"

module bcsr_channel #(
    parameter OC_END_COUNT = `BCSR_OC_END_COUNT,
    parameter OC_COUNT_WIDTH = `BCSR_OC_COUNT_WIDTH
) (
    input wire clk_sys,
    input wire srst,
    input wire regulator_enabled,
    input wire soft_start_done,
    input wire output_in_regulation,
    input wire high_side_overcurrent,
    input wire reverse_current_hit,
    input wire zero_cross_trip,
    input wire automatic_pulse_skip_mode,
    input wire overcurrent_retry_enable,
    input wire read_clear,
    output wire [7:0] status,
    output wire retry_restart,
    output wire latch_off
);

    // ----------------------------------------------------------------
    // two-stage synchronisers for analog inputs
    // ----------------------------------------------------------------
    reg [5:0] sync_a;
    reg [5:0] sync_b;
    always @(posedge clk_sys) begin
        if (srst) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {regulator_enabled, soft_start_done, output_in_regulation,
                       high_side_overcurrent, reverse_current_hit, zero_cross_trip};
            sync_b <= sync_a;
        end
    end

    wire on_s = sync_b[5];
    wire ss_s = sync_b[4];
    wire pg_s = sync_b[3];
    wire oc_s = sync_b[2];
    wire neg_s = sync_b[1];
    wire zc_s = sync_b[0];

    // ----------------------------------------------------------------
    // high-side overcurrent event counter
    // ----------------------------------------------------------------
    reg oc_prev;
    reg [OC_COUNT_WIDTH-1:0] oc_count;
    wire oc_at_end = (oc_count == OC_END_COUNT[OC_COUNT_WIDTH-1:0]);
    always @(posedge clk_sys) begin
        if (srst) begin
            oc_prev <= 1'b0;
            oc_count <= {OC_COUNT_WIDTH{1'b0}};
        end else begin
            oc_prev <= oc_s;
            if (pg_s)
                oc_count <= {OC_COUNT_WIDTH{1'b0}};
            else if (oc_s && !oc_prev && !oc_at_end)
                oc_count <= oc_count + {{(OC_COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // latched flags: set wins over a clearing read
    // ----------------------------------------------------------------
    reg fault_flag;
    reg retry_flag;
    reg reverse_flag;
    reg zero_cross_flag;
    reg ramp_complete;
    reg in_reg;
    reg on_status;

    wire retry_cond = oc_at_end && !pg_s;
    wire next_retry_flag = retry_cond | (retry_flag & ~read_clear);
    wire fault_cond = next_retry_flag || (on_s && ss_s && !pg_s);
    wire reverse_cond = neg_s;
    wire zero_cross_cond = zc_s && automatic_pulse_skip_mode;

    always @(posedge clk_sys) begin
        if (srst) begin
            fault_flag <= 1'b0;
            retry_flag <= 1'b0;
            reverse_flag <= 1'b0;
            zero_cross_flag <= 1'b0;
            ramp_complete <= 1'b0;
            in_reg <= 1'b0;
            on_status <= 1'b0;
        end else begin
            fault_flag <= fault_cond | (fault_flag & ~read_clear);
            retry_flag <= next_retry_flag;
            reverse_flag <= reverse_cond | (reverse_flag & ~read_clear);
            zero_cross_flag <= zero_cross_cond | (zero_cross_flag & ~read_clear);
            ramp_complete <= on_s & ss_s;
            in_reg <= pg_s;
            on_status <= on_s;
        end
    end

    assign status = {fault_flag, retry_flag, reverse_flag, zero_cross_flag,
                     1'b0, ramp_complete, in_reg, on_status};

    // response to repeated overcurrent
    assign retry_restart = retry_flag & overcurrent_retry_enable;
    assign latch_off = retry_flag & ~overcurrent_retry_enable;

endmodule // bcsr_channel

/* File: bcsr_regs.v */
// buck two and three status registers behind the serial control port
`timescale 1ns/100ps
`include "bcsr_defines.vh"

// Operation
// - fault: retry flag, or on, ramped, not good
// - retry flag: overcurrent counter end, power not good
// - retry enable selects restart or latch-off
// - reverse current limit reached latches flag
// - zero crossing flag only in pulse-skip mode
// - bit three reads zero, software keeps zero
// - ramp bit: enabled and soft start finished
// - regulation bit follows comparator live
// - on bit shows channel currently enabled
// - latched flags reset zero, cleared by read
// - read clears only when condition gone
module bcsr_regs #(
    parameter DEVICE_ADDRESS = `BCSR_DEVICE_ADDRESS,
    parameter OC_END_COUNT = `BCSR_OC_END_COUNT,
    parameter OC_COUNT_WIDTH = `BCSR_OC_COUNT_WIDTH
) (
    input wire clk_sys,
    input wire srst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_n,
    input wire buck_two_enabled,
    input wire buck_two_soft_start_done,
    input wire buck_two_in_regulation,
    input wire buck_two_high_side_overcurrent,
    input wire buck_two_reverse_current_hit,
    input wire buck_two_zero_cross_trip,
    input wire buck_two_automatic_pulse_skip_mode,
    input wire buck_two_overcurrent_retry_enable,
    output wire buck_two_retry_restart,
    output wire buck_two_latch_off,
    input wire buck_three_enabled,
    input wire buck_three_soft_start_done,
    input wire buck_three_in_regulation,
    input wire buck_three_high_side_overcurrent,
    input wire buck_three_reverse_current_hit,
    input wire buck_three_zero_cross_trip,
    input wire buck_three_automatic_pulse_skip_mode,
    input wire buck_three_overcurrent_retry_enable,
    output wire buck_three_retry_restart,
    output wire buck_three_latch_off
);

    // ----------------------------------------------------------------
    // serial port states
    // ----------------------------------------------------------------
    localparam ST_IDLE = 9'b000000001;
    localparam ST_DEV = 9'b000000010;
    localparam ST_DEV_ACK = 9'b000000100;
    localparam ST_PTR = 9'b000001000;
    localparam ST_PTR_ACK = 9'b000010000;
    localparam ST_WR = 9'b000100000;
    localparam ST_WR_ACK = 9'b001000000;
    localparam ST_RD = 9'b010000000;
    localparam ST_RD_ACK = 9'b100000000;

    // ----------------------------------------------------------------
    // pin synchronisers and line event detection
    // ----------------------------------------------------------------
    reg scl_s1;
    reg scl_s2;
    reg scl_d;
    reg sda_s1;
    reg sda_s2;
    reg sda_d;
    always @(posedge clk_sys) begin
        if (srst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    wire scl_rise = scl_s2 && !scl_d;
    wire scl_fall = !scl_s2 && scl_d;
    wire start_seen = scl_s2 && scl_d && !sda_s2 && sda_d;
    wire stop_seen = scl_s2 && scl_d && sda_s2 && !sda_d;

    // open-drain line only ever pulls low
    assign sda_out = 1'b0;

    // ----------------------------------------------------------------
    // channel status registers
    // ----------------------------------------------------------------
    wire [7:0] buck_two_status;
    wire [7:0] buck_three_status;
    reg clear_two;
    reg clear_three;

    bcsr_channel #(
        .OC_END_COUNT(OC_END_COUNT),
        .OC_COUNT_WIDTH(OC_COUNT_WIDTH)
    ) u_buck_two (
        .clk_sys(clk_sys),
        .srst(srst),
        .regulator_enabled(buck_two_enabled),
        .soft_start_done(buck_two_soft_start_done),
        .output_in_regulation(buck_two_in_regulation),
        .high_side_overcurrent(buck_two_high_side_overcurrent),
        .reverse_current_hit(buck_two_reverse_current_hit),
        .zero_cross_trip(buck_two_zero_cross_trip),
        .automatic_pulse_skip_mode(buck_two_automatic_pulse_skip_mode),
        .overcurrent_retry_enable(buck_two_overcurrent_retry_enable),
        .read_clear(clear_two),
        .status(buck_two_status),
        .retry_restart(buck_two_retry_restart),
        .latch_off(buck_two_latch_off)
    );

    bcsr_channel #(
        .OC_END_COUNT(OC_END_COUNT),
        .OC_COUNT_WIDTH(OC_COUNT_WIDTH)
    ) u_buck_three (
        .clk_sys(clk_sys),
        .srst(srst),
        .regulator_enabled(buck_three_enabled),
        .soft_start_done(buck_three_soft_start_done),
        .output_in_regulation(buck_three_in_regulation),
        .high_side_overcurrent(buck_three_high_side_overcurrent),
        .reverse_current_hit(buck_three_reverse_current_hit),
        .zero_cross_trip(buck_three_zero_cross_trip),
        .automatic_pulse_skip_mode(buck_three_automatic_pulse_skip_mode),
        .overcurrent_retry_enable(buck_three_overcurrent_retry_enable),
        .read_clear(clear_three),
        .status(buck_three_status),
        .retry_restart(buck_three_retry_restart),
        .latch_off(buck_three_latch_off)
    );

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    reg [7:0] reg_ptr;
    reg [7:0] read_value;
    always @* begin
        case (reg_ptr)
            `BCSR_BUCK_TWO_STATUS_OFS: read_value = buck_two_status;
            `BCSR_BUCK_THREE_STATUS_OFS: read_value = buck_three_status;
            default: read_value = `BCSR_UNMAPPED_READ;
        endcase
    end

    // ----------------------------------------------------------------
    // serial protocol engine
    // ----------------------------------------------------------------
    reg [8:0] state;
    reg [2:0] bit_cnt;
    reg byte_done;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg rd_mode;
    reg master_ack;

    wire addr_match = (shift_in[7:1] == DEVICE_ADDRESS[6:0]);
    wire load_byte = scl_fall && !start_seen && !stop_seen &&
                     ((state == ST_DEV_ACK && rd_mode) || (state == ST_RD_ACK && master_ack));

    // snapshot and clearing read happen on the same edge,
    // so an event arriving at that edge stays latched
    always @* begin
        clear_two = 1'b0;
        clear_three = 1'b0;
        if (load_byte) begin
            clear_two = (reg_ptr == `BCSR_BUCK_TWO_STATUS_OFS);
            clear_three = (reg_ptr == `BCSR_BUCK_THREE_STATUS_OFS);
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            bit_cnt <= `BCSR_BIT_COUNT_ZERO;
            byte_done <= 1'b0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            rd_mode <= 1'b0;
            master_ack <= 1'b0;
            reg_ptr <= 8'h00;
            sda_oe_n <= 1'b1;
        end else if (start_seen) begin
            state <= ST_DEV;
            bit_cnt <= `BCSR_BIT_COUNT_ZERO;
            byte_done <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            case (state)
                ST_DEV, ST_PTR, ST_WR: begin
                    shift_in <= {shift_in[6:0], sda_s2};
                    bit_cnt <= bit_cnt + 3'h1;
                    byte_done <= (bit_cnt == `BCSR_BYTE_LAST_BIT);
                end
                ST_RD: begin
                    bit_cnt <= bit_cnt + 3'h1;
                    byte_done <= (bit_cnt == `BCSR_BYTE_LAST_BIT);
                end
                ST_RD_ACK: begin
                    master_ack <= !sda_s2;
                end
                default: begin
                    byte_done <= 1'b0;
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_DEV: begin
                    if (byte_done) begin
                        byte_done <= 1'b0;
                        if (addr_match) begin
                            state <= ST_DEV_ACK;
                            rd_mode <= shift_in[0];
                            sda_oe_n <= 1'b0;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (rd_mode) begin
                        state <= ST_RD;
                        // load first byte, pointer moves on to the next register
                        reg_ptr <= reg_ptr + 8'h01;
                        shift_out <= {read_value[6:0], 1'b0};
                        sda_oe_n <= read_value[7];
                    end else begin
                        state <= ST_PTR;
                        sda_oe_n <= 1'b1;
                    end
                end
                ST_PTR: begin
                    if (byte_done) begin
                        byte_done <= 1'b0;
                        reg_ptr <= shift_in;
                        state <= ST_PTR_ACK;
                        sda_oe_n <= 1'b0;
                    end
                end
                ST_PTR_ACK: begin
                    state <= ST_WR;
                    sda_oe_n <= 1'b1;
                end
                ST_WR: begin
                    // status registers are read-only; data acknowledged, dropped
                    if (byte_done) begin
                        byte_done <= 1'b0;
                        state <= ST_WR_ACK;
                        sda_oe_n <= 1'b0;
                    end
                end
                ST_WR_ACK: begin
                    state <= ST_WR;
                    sda_oe_n <= 1'b1;
                end
                ST_RD: begin
                    if (byte_done) begin
                        byte_done <= 1'b0;
                        state <= ST_RD_ACK;
                        sda_oe_n <= 1'b1;
                    end else begin
                        sda_oe_n <= shift_out[7];
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                end
                ST_RD_ACK: begin
                    if (master_ack) begin
                        // next register was selected when the previous byte loaded
                        state <= ST_RD;
                        reg_ptr <= reg_ptr + 8'h01;
                        shift_out <= {read_value[6:0], 1'b0};
                        sda_oe_n <= read_value[7];
                    end else begin
                        state <= ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

endmodule // bcsr_regs

/* File: bcsr_regs_sva.sv */
// concurrent checks on the status register block ports
`timescale 1ns/100ps
module bcsr_regs_sva (
    input wire clk_sys,
    input wire srst,
    input wire scl_in,
    input wire sda_oe_n,
    input wire buck_two_in_regulation,
    input wire buck_two_high_side_overcurrent,
    input wire buck_two_overcurrent_retry_enable,
    input wire buck_two_retry_restart,
    input wire buck_two_latch_off,
    input wire buck_three_retry_restart,
    input wire buck_three_latch_off
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire flag_two;
    reg [3:0] scl_hi_cnt;
    assign flag_two = buck_two_retry_restart | buck_two_latch_off;
    // ----
    // cycles since the serial clock was last low
    // ----
    always @(posedge clk_sys) begin
        if (srst || !scl_in) begin
            scl_hi_cnt <= 4'h0;
        end else if (scl_hi_cnt != 4'hF) begin
            scl_hi_cnt <= scl_hi_cnt + 4'h1;
        end
    end
    a_restart_gate: assert property (buck_two_retry_restart |-> buck_two_overcurrent_retry_enable)
        else $error("restart without retry enable");
    a_latch_gate: assert property (buck_two_latch_off |-> !buck_two_overcurrent_retry_enable)
        else $error("latch-off with retry enable");
    a_retry_exclusive: assert property (!(buck_two_retry_restart && buck_two_latch_off) &&
        !(buck_three_retry_restart && buck_three_latch_off))
        else $error("restart and latch-off together");
    a_flag_sticky: assert property ($fell(flag_two) |-> scl_hi_cnt < 4'h8)
        else $error("retry flag dropped outside a read");
    a_retry_pg_low: assert property ($rose(flag_two) |-> !$past(buck_two_in_regulation, 2) ||
        !$past(buck_two_in_regulation, 3) || !$past(buck_two_in_regulation, 4))
        else $error("retry flag set while power good");
    a_retry_after_oc: assert property ($rose(flag_two) |-> $past(buck_two_high_side_overcurrent, 2) ||
        $past(buck_two_high_side_overcurrent, 3) || $past(buck_two_high_side_overcurrent, 4))
        else $error("retry flag set without overcurrent event");
    a_oe_reset: assert property ($fell(srst) |-> sda_oe_n)
        else $error("data line pulled at reset release");
    a_drive_after_fall: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 1) && !$past(scl_in, 2))
        else $error("data line driven while clock high");
    cover property (buck_two_retry_restart);
    cover property (buck_two_latch_off);
    cover property ($fell(flag_two));
    cover property ($fell(sda_oe_n));
endmodule // bcsr_regs_sva

bind bcsr_regs bcsr_regs_sva u_bcsr_regs_sva (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in),
    .sda_oe_n(sda_oe_n), .buck_two_in_regulation(buck_two_in_regulation),
    .buck_two_high_side_overcurrent(buck_two_high_side_overcurrent),
    .buck_two_overcurrent_retry_enable(buck_two_overcurrent_retry_enable),
    .buck_two_retry_restart(buck_two_retry_restart), .buck_two_latch_off(buck_two_latch_off),
    .buck_three_retry_restart(buck_three_retry_restart), .buck_three_latch_off(buck_three_latch_off));

/* File: bcsr_host.sv */
// serial control port master standing for the host processor
`timescale 1ns/100ps
module bcsr_host (
    input wire clk_sys,
    input wire sda_line,
    output reg scl,
    output reg sda_rel
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // ----
    // bit level, quarter period of three clocks
    // ----
    task hq;
        begin
            repeat (3) @(posedge clk_sys);
            #1;
        end
    endtask
    task bit_io(input b, output r);
        begin
            hq;
            sda_rel = b;
            hq;
            scl = 1'b1;
            hq;
            r = sda_line;
            hq;
            scl = 1'b0;
        end
    endtask
    task start;
        begin
            hq;
            sda_rel = 1'b1;
            hq;
            scl = 1'b1;
            hq;
            sda_rel = 1'b0;
            hq;
            scl = 1'b0;
        end
    endtask
    task stop;
        begin
            hq;
            sda_rel = 1'b0;
            hq;
            scl = 1'b1;
            hq;
            sda_rel = 1'b1;
            hq;
        end
    endtask
    task byte_io(input [7:0] d, input ackb, output [7:0] r, output a);
        integer i;
        begin
            for (i = 7; i >= 0; i--) begin
                bit_io(d[i], r[i]);
            end
            bit_io(ackb, a);
        end
    endtask
    // ----
    // register transfers
    // ----
    task read_reg(input [6:0] ad, input [7:0] ptr, input two, output [7:0] d0, output [7:0] d1, output nak);
        reg [7:0] x;
        reg a;
        begin
            start;
            byte_io({ad, 1'b0}, 1'b1, x, nak);
            byte_io(ptr, 1'b1, x, a);
            nak |= a;
            start;
            byte_io({ad, 1'b1}, 1'b1, x, a);
            nak |= a;
            byte_io(8'hFF, !two, d0, a);
            d1 = 8'h00;
            if (two) begin
                byte_io(8'hFF, 1'b1, d1, a);
            end
            stop;
        end
    endtask
    task write_reg(input [6:0] ad, input [7:0] ptr, input [7:0] d, output nak);
        reg [7:0] x;
        reg a;
        begin
            start;
            byte_io({ad, 1'b0}, 1'b1, x, nak);
            byte_io(ptr, 1'b1, x, a);
            nak |= a;
            byte_io(d & 8'hF7, 1'b1, x, a);
            nak |= a;
            stop;
        end
    endtask
endmodule // bcsr_host

/* File: tb_top.sv */
// testbench for the buck channel status registers
`timescale 1ns/100ps
`include "bcsr_defines.vh"
module tb_top;
    localparam [6:0] ADDR = `BCSR_DEVICE_ADDRESS;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    // channel inputs: en, ss, pg, oc, rev, zc, skip, retry_en
    reg [7:0] c2 = 8'h00;
    reg [7:0] c3 = 8'h00;
    wire scl, sda_rel, sda_out, sda_oe_n, sda_line, r2, l2, r3, l3;
    integer error_cnt = 0;
    integer num_checks = 0;
    reg [7:0] d0, d1;
    reg nak;
    assign sda_line = sda_rel & (sda_oe_n ? 1'b1 : sda_out);
    always #10 clk_sys = ~clk_sys;
    bcsr_host u_bcsr_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    bcsr_regs #(.OC_END_COUNT(2)) u_bcsr_regs (.clk_sys(clk_sys), .srst(srst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .buck_two_enabled(c2[0]), .buck_two_soft_start_done(c2[1]), .buck_two_in_regulation(c2[2]),
        .buck_two_high_side_overcurrent(c2[3]), .buck_two_reverse_current_hit(c2[4]),
        .buck_two_zero_cross_trip(c2[5]), .buck_two_automatic_pulse_skip_mode(c2[6]),
        .buck_two_overcurrent_retry_enable(c2[7]), .buck_two_retry_restart(r2), .buck_two_latch_off(l2),
        .buck_three_enabled(c3[0]), .buck_three_soft_start_done(c3[1]), .buck_three_in_regulation(c3[2]),
        .buck_three_high_side_overcurrent(c3[3]), .buck_three_reverse_current_hit(c3[4]),
        .buck_three_zero_cross_trip(c3[5]), .buck_three_automatic_pulse_skip_mode(c3[6]),
        .buck_three_overcurrent_retry_enable(c3[7]), .buck_three_retry_restart(r3), .buck_three_latch_off(l3));
    task check(input [7:0] seen, input [7:0] exp);
        begin
            num_checks++;
            if (seen !== exp) begin
                error_cnt++;
                $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input [7:0] ptr, input [7:0] exp);
        begin
            u_bcsr_host.read_reg(ADDR, ptr, 1'b0, d0, d1, nak);
            check({7'h00, nak}, 8'h00);
            check(d0, exp);
        end
    endtask
    task setc(input [7:0] v2, input [7:0] v3);
        begin
            @(posedge clk_sys);
            #1;
            c2 = v2;
            c3 = v3;
            repeat (5) @(posedge clk_sys);
        end
    endtask
    task do_reset;
        begin
            @(posedge clk_sys);
            #1;
            srst = 1'b1;
            repeat (3) @(posedge clk_sys);
            #1;
            srst = 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (80000) @(posedge clk_sys);
        error_cnt++;
        $display("[ERR] %0t: run did not finish", $time);
        complete_run;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clk_sys);
        // ----
        // reset values, unmapped pointer, wrong address
        // ----
        rd(8'h06, `BCSR_STATUS_RESET);
        rd(8'h07, `BCSR_STATUS_RESET);
        rd(8'h09, `BCSR_UNMAPPED_READ);
        u_bcsr_host.read_reg(ADDR ^ 7'h01, 8'h06, 1'b0, d0, d1, nak);
        check({7'h00, nak}, 8'h01);
        $display("test 1 done");
        // ----
        // live bits, ignored write, pointer increment
        // ----
        setc(8'h07, 8'h06);
        u_bcsr_host.write_reg(ADDR, 8'h06, 8'hFF, nak);
        u_bcsr_host.read_reg(ADDR, 8'h06, 1'b1, d0, d1, nak);
        check(d0, 8'h07);
        check(d1, 8'h02);
        $display("test 2 done");
        // ----
        // fault flag kept while condition lasts
        // ----
        setc(8'h03, 8'h00);
        rd(8'h06, 8'h85);
        rd(8'h06, 8'h85);
        setc(8'h07, 8'h00);
        rd(8'h06, 8'h87);
        rd(8'h06, 8'h07);
        $display("test 3 done");
        // ----
        // reverse current and zero crossing flags
        // ----
        setc(8'h00, 8'h10);
        setc(8'h00, 8'h00);
        rd(8'h07, 8'h20);
        rd(8'h07, 8'h00);
        setc(8'h00, 8'h20);
        setc(8'h00, 8'h00);
        rd(8'h07, 8'h00);
        setc(8'h00, 8'h60);
        setc(8'h00, 8'h40);
        rd(8'h07, 8'h10);
        rd(8'h07, 8'h00);
        $display("test 4 done");
        // ----
        // repeated overcurrent at end count, retry and latch-off
        // ----
        setc(8'h88, 8'h00);
        setc(8'h80, 8'h00);
        rd(8'h06, 8'h00);
        setc(8'h88, 8'h00);
        setc(8'h80, 8'h00);
        check({4'h0, r2, l2, r3, l3}, 8'h08);
        rd(8'h06, 8'hC0);
        rd(8'h06, 8'hC0);
        setc(8'h00, 8'h00);
        check({4'h0, r2, l2, r3, l3}, 8'h04);
        setc(8'h04, 8'h00);
        rd(8'h06, 8'hC2);
        rd(8'h06, 8'h02);
        do_reset;
        rd(8'h06, 8'h02);
        check({4'h0, r2, l2, r3, l3}, 8'h00);
        $display("test 5 done");
        complete_run;
    end
endmodule // tb_top
